// ---- verilog/etfc_pkg.sv ----
package etfc_pkg;

  // Buffer geometry and search depth.
  localparam int         FRAME_DEPTH  = 1000;
  localparam int         IDX_W        = 10;
  localparam int         FIFO_DEPTH   = 8;
  localparam logic [9:0] LAST_IDX     = 10'h3e7;
  localparam logic [9:0] FRAME_CAP    = 10'h3e8;
  localparam logic [9:0] SEARCH_SPAN  = 10'h010;
  localparam logic [4:0] SEARCH_LEFT  = 5'h10;

  // Reset values.
  localparam logic [9:0]  IDX_RST       = 10'h000;
  localparam logic [9:0]  COUNT_RST     = 10'h000;
  localparam logic [15:0] LAST_ADDR_RST = 16'h0000;
  localparam logic [7:0]  OPCODE_RST    = 8'h00;
  localparam logic [15:0] RD_DATA_RST   = 16'h0000;

  // Frame types.
  typedef enum logic [1:0] {
    FT_INSTR_ADDR,
    FT_OPCODE,
    FT_VALUE_ADDR,
    FT_VALUE
  } etfc_ftype_t;

  // Fields that a host read may select.
  typedef enum logic [3:0] {
    FLD_ADDR,
    FLD_DATA,
    FLD_ADDR_DATA_FLAG,
    FLD_FETCH_ORDER,
    FLD_MUXED_LOW,
    FLD_GENERAL,
    FLD_HIGH_ADDR,
    FLD_EXT_ADDR,
    FLD_OVERFLOW
  } etfc_field_t;

  typedef struct packed {
    logic [7:0] high_addr_port;
    logic [7:0] general_port;
    logic [7:0] muxed_low_port;
  } etfc_ports_t;

  // One bus cycle as offered by the emulated controller.
  typedef struct packed {
    etfc_ftype_t ftype;
    logic        fetch_order_flag;
    logic [15:0] code_addr;
    logic [7:0]  data_byte;
    etfc_ports_t ports;
  } etfc_capture_t;

  // One stored frame record.
  typedef struct packed {
    etfc_ftype_t ftype;
    logic        fetch_order_flag;
    logic [15:0] value;
    etfc_ports_t ports;
    logic        trace_overflow_flag;
  } etfc_frame_t;

endpackage : etfc_pkg

// ---- verilog/etfc_fifo.sv ----
module etfc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rstn,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  store_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          ready_q;
  logic          push;
  logic          pop;

  assign push      = in_valid && ready_q;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = store_q[rd_ptr_q];
  assign in_ready  = ready_q;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      ready_q <= (count_d != CW'(DEPTH));
    end
  end

endmodule : etfc_fifo

// ---- verilog/etfc_frame_mem.sv ----
module etfc_frame_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 1000,
  parameter int AW    = 10
) (
  // Clock.
  input  wire logic          clk,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Registered read port.
  input  wire logic [AW-1:0] raddr,
  output logic [W-1:0]       rdata_q
);

  logic [W-1:0] store_q [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      store_q[waddr] <= wdata;
    end
    rdata_q <= store_q[raddr];
  end

endmodule : etfc_frame_mem

// ---- verilog/etfc_trace_capture.sv ----
module etfc_trace_capture
  import etfc_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rstn,
  // Captured bus cycles.
  input  wire logic          cap_valid,
  output logic               cap_ready,
  input  wire etfc_capture_t cap_frame,
  // Emulation break.
  input  wire logic          emu_break,
  // Host field read.
  input  wire logic          rd_req,
  input  wire etfc_field_t   rd_field,
  input  wire logic [9:0]    disp_ptr,
  input  wire logic          trace_frame_mode,
  output logic               rd_done,
  output logic               rd_err,
  output logic [15:0]        rd_data,
  output logic               rd_frame_mode,
  // Status.
  output logic [9:0]         frame_count,
  output logic               trace_overflow_flag,
  output logic [15:0]        last_instr_address,
  output logic [7:0]         last_opcode,
  output logic               search_done,
  output logic               no_update
);

  typedef enum logic [1:0] {ST_IDLE, ST_HREAD, ST_SREAD, ST_SCHECK} etfc_state_t;

  etfc_state_t   state_q;
  etfc_capture_t fifo_out;
  logic          fifo_out_valid;
  logic          drain_ready;
  logic          mem_we;
  etfc_frame_t   wframe;
  etfc_frame_t   rframe;
  logic [9:0]    mem_raddr;
  logic [9:0]    wr_idx_q;
  logic [9:0]    frame_count_q;
  logic          overflow_q;
  logic          brk_pend_q;
  logic          rd_pend_q;
  logic          brk_take;
  logic          rd_take;
  logic [9:0]    rd_ptr_q;
  etfc_field_t   rd_fld_q;
  logic          rd_mode_q;
  logic [9:0]    cur_ptr;
  etfc_field_t   cur_fld;
  logic          cur_mode;
  logic [10:0]   host_sum;
  logic [9:0]    host_phys;
  logic          host_err;
  logic          rd_err_pend_q;
  logic          rd_done_q;
  logic          rd_err_q;
  logic [15:0]   rd_data_q;
  logic          rd_frame_mode_q;
  logic [9:0]    srch_idx_q;
  logic [4:0]    srch_left_q;
  logic          newer_is_opcode_q;
  logic [7:0]    newer_data_q;
  logic [15:0]   last_addr_q;
  logic [7:0]    last_opcode_q;
  logic          search_done_q;
  logic          no_update_q;

  etfc_fifo #(
    .W     ($bits(etfc_capture_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (cap_frame),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out)
  );

  etfc_frame_mem #(
    .W     ($bits(etfc_frame_t)),
    .DEPTH (FRAME_DEPTH),
    .AW    (IDX_W)
  ) u_mem (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (wr_idx_q),
    .wdata   (wframe),
    .raddr   (mem_raddr),
    .rdata_q (rframe)
  );

  // Frames are held back while the break search walks the buffer.
  assign drain_ready = (state_q == ST_IDLE && !brk_take) || (state_q == ST_HREAD);
  assign mem_we      = fifo_out_valid && drain_ready;

  always_comb begin
    wframe.ftype            = fifo_out.ftype;
    wframe.fetch_order_flag = fifo_out.fetch_order_flag;
    wframe.value = (fifo_out.ftype == FT_INSTR_ADDR || fifo_out.ftype == FT_VALUE_ADDR)
                   ? fifo_out.code_addr : {8'h00, fifo_out.data_byte};
    wframe.ports               = fifo_out.ports;
    wframe.trace_overflow_flag = overflow_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_idx_q      <= IDX_RST;
      frame_count_q <= COUNT_RST;
      overflow_q    <= 1'b0;
    end else if (mem_we) begin
      wr_idx_q <= (wr_idx_q == LAST_IDX) ? IDX_RST : wr_idx_q + 10'h001;
      if (frame_count_q != FRAME_CAP) begin
        frame_count_q <= frame_count_q + 10'h001;
      end
      if (frame_count_q == LAST_IDX) begin
        overflow_q <= 1'b1;
      end
    end
  end

  // Host read: the display pointer counts from the oldest frame.
  assign cur_ptr   = rd_req ? disp_ptr : rd_ptr_q;
  assign cur_fld   = rd_req ? rd_field : rd_fld_q;
  assign cur_mode  = rd_req ? trace_frame_mode : rd_mode_q;
  assign host_sum  = {1'b0, wr_idx_q} + {1'b0, cur_ptr};
  assign host_err  = (frame_count_q == COUNT_RST) || (cur_ptr >= frame_count_q);
  assign brk_take  = (state_q == ST_IDLE) && (emu_break || brk_pend_q);
  assign rd_take   = (state_q == ST_IDLE) && (rd_req || rd_pend_q) && !brk_take;

  assign host_phys = !overflow_q ? cur_ptr
                   : (host_sum >= {1'b0, FRAME_CAP}) ? 10'(host_sum - {1'b0, FRAME_CAP})
                   : host_sum[9:0];

  assign mem_raddr = (state_q == ST_IDLE) ? host_phys : srch_idx_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      brk_pend_q <= 1'b0;
      rd_pend_q  <= 1'b0;
      rd_ptr_q   <= IDX_RST;
      rd_fld_q   <= FLD_ADDR;
      rd_mode_q  <= 1'b0;
    end else begin
      brk_pend_q <= (emu_break || brk_pend_q) && !brk_take;
      rd_pend_q  <= (rd_req || rd_pend_q) && !rd_take;
      if (rd_req || rd_take) begin
        rd_ptr_q  <= cur_ptr;
        rd_fld_q  <= cur_fld;
        rd_mode_q <= cur_mode;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (brk_take && frame_count_q != COUNT_RST) begin
            state_q <= ST_SREAD;
          end else if (rd_take) begin
            state_q <= ST_HREAD;
          end
        end
        ST_HREAD:  state_q <= ST_IDLE;
        ST_SREAD:  state_q <= ST_SCHECK;
        ST_SCHECK: state_q <= (rframe.ftype == FT_INSTR_ADDR || srch_left_q == 5'h01)
                              ? ST_IDLE : ST_SREAD;
      endcase
    end
  end

  // Field answer, built from the frame read in the previous cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_err_pend_q   <= 1'b0;
      rd_done_q       <= 1'b0;
      rd_err_q        <= 1'b0;
      rd_data_q       <= RD_DATA_RST;
      rd_frame_mode_q <= 1'b0;
    end else begin
      rd_done_q <= (state_q == ST_HREAD);
      if (rd_take) begin
        rd_err_pend_q <= host_err;
      end
      if (state_q == ST_HREAD) begin
        rd_err_q        <= rd_err_pend_q;
        rd_frame_mode_q <= rd_mode_q;
        if (rd_err_pend_q) begin
          rd_data_q <= RD_DATA_RST;
        end else begin
          case (rd_fld_q)
            FLD_ADDR:           rd_data_q <= rframe.value;
            FLD_DATA:           rd_data_q <= {8'h00, rframe.value[7:0]};
            FLD_ADDR_DATA_FLAG: rd_data_q <= {15'h0000,
                                              rframe.ftype == FT_OPCODE ||
                                              rframe.ftype == FT_VALUE};
            FLD_FETCH_ORDER:    rd_data_q <= {15'h0000, rframe.fetch_order_flag};
            FLD_MUXED_LOW:      rd_data_q <= {8'h00, rframe.ports.muxed_low_port};
            FLD_GENERAL:        rd_data_q <= {8'h00, rframe.ports.general_port};
            FLD_HIGH_ADDR:      rd_data_q <= {8'h00, rframe.ports.high_addr_port};
            FLD_EXT_ADDR:       rd_data_q <= {rframe.ports.high_addr_port,
                                              rframe.ports.muxed_low_port};
            FLD_OVERFLOW:       rd_data_q <= {15'h0000, rframe.trace_overflow_flag};
            default:            rd_data_q <= RD_DATA_RST;
          endcase
        end
      end
    end
  end

  // Break search from the pointer_past_end frame backwards.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      srch_idx_q     <= IDX_RST;
      srch_left_q    <= 5'h00;
      newer_is_opcode_q <= 1'b0;
      newer_data_q   <= OPCODE_RST;
      last_addr_q    <= LAST_ADDR_RST;
      last_opcode_q  <= OPCODE_RST;
      search_done_q  <= 1'b0;
      no_update_q    <= 1'b0;
    end else begin
      search_done_q <= 1'b0;
      if (brk_take) begin
        srch_idx_q     <= (wr_idx_q == IDX_RST) ? LAST_IDX : wr_idx_q - 10'h001;
        srch_left_q    <= (frame_count_q >= SEARCH_SPAN) ? SEARCH_LEFT
                                                         : frame_count_q[4:0];
        newer_is_opcode_q <= 1'b0;
        if (frame_count_q == COUNT_RST) begin
          search_done_q <= 1'b1;
          no_update_q   <= 1'b1;
        end
      end else if (state_q == ST_SCHECK) begin
        if (rframe.ftype == FT_INSTR_ADDR) begin
          last_addr_q   <= rframe.value;
          if (newer_is_opcode_q) begin
            last_opcode_q <= newer_data_q;
          end
          search_done_q <= 1'b1;
          no_update_q   <= 1'b0;
        end else if (srch_left_q == 5'h01) begin
          search_done_q <= 1'b1;
          no_update_q   <= 1'b1;
        end else begin
          srch_left_q    <= srch_left_q - 5'h01;
          srch_idx_q     <= (srch_idx_q == IDX_RST) ? LAST_IDX : srch_idx_q - 10'h001;
          newer_is_opcode_q <= (rframe.ftype == FT_OPCODE);
          newer_data_q   <= rframe.value[7:0];
        end
      end
    end
  end

  assign rd_done             = rd_done_q;
  assign rd_err              = rd_err_q;
  assign rd_data             = rd_data_q;
  assign rd_frame_mode       = rd_frame_mode_q;
  assign frame_count         = frame_count_q;
  assign trace_overflow_flag = overflow_q;
  assign last_instr_address  = last_addr_q;
  assign last_opcode         = last_opcode_q;
  assign search_done         = search_done_q;
  assign no_update           = no_update_q;

  property p_count_sat;
    @(posedge clk) disable iff (!rstn) frame_count_q <= FRAME_CAP;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("frame count above cap");

  property p_count_inc;
    @(posedge clk) disable iff (!rstn)
      mem_we && frame_count_q != FRAME_CAP |=> frame_count_q == $past(frame_count_q) + 10'h001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("frame count missed a frame");

  property p_idx_wrap;
    @(posedge clk) disable iff (!rstn) mem_we && wr_idx_q == LAST_IDX |=> wr_idx_q == IDX_RST;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("write index did not wrap");

  property p_ovf_frame;
    @(posedge clk) disable iff (!rstn)
      mem_we |-> wframe.trace_overflow_flag == (frame_count_q == FRAME_CAP);
  endproperty
  a_ovf_frame: assert property (p_ovf_frame) else $error("overflow flag wrong on frame");

  property p_empty_err;
    @(posedge clk) disable iff (!rstn)
      rd_take && frame_count_q == COUNT_RST |-> ##2 rd_done_q && rd_err_q;
  endproperty
  a_empty_err: assert property (p_empty_err) else $error("empty buffer read not refused");

  property p_search_bound;
    @(posedge clk) disable iff (!rstn) brk_take |-> ##[0:40] search_done_q;
  endproperty
  a_search_bound: assert property (p_search_bound) else $error("break search too long");

  property p_search_hold;
    @(posedge clk) disable iff (!rstn)
      (state_q == ST_SREAD || state_q == ST_SCHECK) |-> !mem_we && $stable(wr_idx_q);
  endproperty
  a_search_hold: assert property (p_search_hold) else $error("frame written during search");

  property p_ext_addr;
    @(posedge clk) disable iff (!rstn)
      state_q == ST_HREAD && rd_fld_q == FLD_EXT_ADDR && !rd_err_pend_q
      |=> rd_data_q == {$past(rframe.ports.high_addr_port), $past(rframe.ports.muxed_low_port)};
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("external address misformed");

endmodule : etfc_trace_capture

// ---- bench/etfc_bus_model.sv ----
module etfc_bus_model
  import etfc_pkg::*;
(
  // Clock and reset.
  input  wire logic     clk,
  input  wire logic     rstn,
  // Bus cycle offer.
  output etfc_capture_t cap_frame,
  output logic          cap_valid,
  input  wire logic     cap_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cap_valid = 1'b0;
    cap_frame = '0;
  end

  // Offers one bus cycle, after an optional stall, and holds it until taken.
  task automatic send(input etfc_capture_t f, input int gap);
    if (cap_valid !== 1'b1 || rstn !== 1'b1) begin
      @(posedge clk);
    end
    if (gap != 0) begin
      cap_valid <= 1'b0;
      cap_frame <= etfc_capture_t'(~cap_frame);
      repeat (gap) @(posedge clk);
    end
    cap_valid <= 1'b1;
    cap_frame <= f;
    do @(posedge clk); while (cap_ready !== 1'b1);
  endtask : send

  // Withdraws the offer and scrambles the released lines.
  task automatic idle();
    cap_valid <= 1'b0;
    cap_frame <= etfc_capture_t'(~cap_frame);
  endtask : idle
endmodule : etfc_bus_model

// ---- bench/testbench.sv ----
module testbench
  import etfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          clk, rstn, cap_valid, cap_ready, emu_break, rd_req, trace_frame_mode;
  logic          rd_done, rd_err, rd_frame_mode, trace_overflow_flag, search_done, no_update;
  logic          saw_full;
  logic [9:0]    disp_ptr, frame_count;
  logic [15:0]   rd_data, last_instr_address, exp_addr;
  logic [7:0]    last_opcode, exp_opcode;
  etfc_capture_t cap_frame;
  etfc_field_t   rd_field;
  etfc_capture_t sb[$];
  int            fails, n_compared, cycles, i;

  etfc_trace_capture u_dut (.clk(clk), .rstn(rstn), .cap_valid(cap_valid),
    .cap_ready(cap_ready), .cap_frame(cap_frame), .emu_break(emu_break), .rd_req(rd_req),
    .rd_field(rd_field), .disp_ptr(disp_ptr), .trace_frame_mode(trace_frame_mode),
    .rd_done(rd_done), .rd_err(rd_err), .rd_data(rd_data), .rd_frame_mode(rd_frame_mode),
    .frame_count(frame_count), .trace_overflow_flag(trace_overflow_flag),
    .last_instr_address(last_instr_address), .last_opcode(last_opcode),
    .search_done(search_done), .no_update(no_update));
  etfc_bus_model u_bus (.clk(clk), .rstn(rstn), .cap_frame(cap_frame),
    .cap_valid(cap_valid), .cap_ready(cap_ready));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (rstn === 1'b1 && cap_ready === 1'b0) saw_full = 1'b1;
    if (cycles == 40000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] exp_fld(etfc_capture_t c, etfc_field_t f, logic ovf);
    case (f)
      FLD_ADDR:           return c.code_addr;
      FLD_DATA:           return {8'h00, c.data_byte};
      FLD_ADDR_DATA_FLAG: return {15'h0000, c.ftype inside {FT_OPCODE, FT_VALUE}};
      FLD_FETCH_ORDER:    return {15'h0000, c.fetch_order_flag};
      FLD_MUXED_LOW:      return {8'h00, c.ports.muxed_low_port};
      FLD_GENERAL:        return {8'h00, c.ports.general_port};
      FLD_HIGH_ADDR:      return {8'h00, c.ports.high_addr_port};
      FLD_EXT_ADDR:       return {c.ports.high_addr_port, c.ports.muxed_low_port};
      default:            return {15'h0000, ovf};
    endcase
  endfunction : exp_fld

  task automatic push(input etfc_ftype_t t, input int gap);
    etfc_capture_t c;
    c.ftype = t;
    c.fetch_order_flag = 1'($urandom_range(1));
    c.code_addr = 16'($urandom);
    c.data_byte = 8'($urandom);
    c.ports = etfc_ports_t'(24'($urandom));
    sb.push_back(c);
    u_bus.send(c, gap);
  endtask : push

  task automatic settle();
    int k;
    int n;
    n = (sb.size() > 1000) ? 1000 : sb.size();
    u_bus.idle();
    for (k = 0; k < 300 && frame_count !== 10'(n); k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("frame_count", 16'(frame_count), 16'(n));
  endtask : settle

  task automatic rd(input int ptr, input etfc_field_t f, output logic e, output logic [15:0] d);
    logic m;
    int k;
    m = 1'($urandom_range(1));
    @(posedge clk);
    rd_req <= 1'b1;
    rd_field <= f;
    disp_ptr <= 10'(ptr);
    trace_frame_mode <= m;
    @(posedge clk);
    rd_req <= 1'b0;
    for (k = 0; k < 60 && rd_done !== 1'b1; k++) @(negedge clk);
    e = rd_err;
    d = rd_data;
    chk("rd_frame_mode", 16'(rd_frame_mode), 16'(m));
  endtask : rd

  task automatic rd_frame(input int ptr);
    etfc_capture_t c;
    etfc_field_t f;
    logic e;
    logic [15:0] d;
    int idx;
    idx = (sb.size() > 1000) ? sb.size() - 1000 + ptr : ptr;
    c = sb[idx];
    for (int k = 0; k < 9; k++) begin
      f = etfc_field_t'(k);
      if (f == FLD_ADDR && c.ftype inside {FT_OPCODE, FT_VALUE}) continue;
      if (f == FLD_DATA && c.ftype inside {FT_INSTR_ADDR, FT_VALUE_ADDR}) continue;
      rd(ptr, f, e, d);
      chk("rd_err", 16'(e), 16'h0000);
      chk(f.name(), d, exp_fld(c, f, idx >= 1000));
    end
  endtask : rd_frame

  task automatic rd_bad(input int ptr);
    logic e;
    logic [15:0] d;
    rd(ptr, FLD_GENERAL, e, d);
    chk("rd_err", 16'(e), 16'h0001);
    chk("rd_data", d, 16'h0000);
  endtask : rd_bad

  task automatic brk();
    int n;
    int k;
    logic found;
    n = sb.size();
    found = 1'b0;
    for (k = n - 1; k >= n - 16 && k >= 0 && !found; k--) begin
      if (sb[k].ftype == FT_INSTR_ADDR) begin
        found = 1'b1;
        exp_addr = sb[k].code_addr;
        if (k + 1 < n && sb[k + 1].ftype == FT_OPCODE) exp_opcode = sb[k + 1].data_byte;
      end
    end
    @(posedge clk);
    emu_break <= 1'b1;
    @(posedge clk);
    emu_break <= 1'b0;
    for (k = 0; k < 80 && search_done !== 1'b1; k++) @(negedge clk);
    chk("search_done", 16'(search_done), 16'h0001);
    chk("no_update", 16'(no_update), 16'(!found));
    chk("last_instr_address", last_instr_address, exp_addr);
    chk("last_opcode", 16'(last_opcode), 16'(exp_opcode));
  endtask : brk

  initial begin
    rstn = 1'b0;
    emu_break = 1'b0;
    rd_req = 1'b0;
    rd_field = FLD_ADDR;
    disp_ptr = 10'h000;
    trace_frame_mode = 1'b0;
    saw_full = 1'b0;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    exp_addr = 16'h0000;
    exp_opcode = 8'h00;
    void'($urandom(32'h10b91383));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("cap_ready", 16'(cap_ready), 16'h0001);
    chk("frame_count", 16'(frame_count), 16'h0000);
    chk("trace_overflow_flag", 16'(trace_overflow_flag), 16'h0000);
    rd_bad(0);
    brk();
    // Every frame type first, then random traffic with stalls.
    push(FT_INSTR_ADDR, 0);
    push(FT_OPCODE, 0);
    push(FT_VALUE_ADDR, 0);
    push(FT_VALUE, 0);
    repeat (16) push(etfc_ftype_t'($urandom_range(3)), $urandom_range(2));
    settle();
    for (i = 0; i < 20; i++) rd_frame(i);
    rd_bad(20);
    rd_bad(1023);
    brk();
    // Location with opcode behind trailing data frames, then a bare location.
    push(FT_INSTR_ADDR, 0);
    push(FT_OPCODE, 0);
    push(FT_VALUE, 0);
    push(FT_VALUE_ADDR, 0);
    push(FT_VALUE, 0);
    settle();
    brk();
    push(FT_INSTR_ADDR, 0);
    settle();
    brk();
    // No location in the pointer_past_end sixteen, while a burst fills the FIFO.
    repeat (17) push(FT_VALUE, 0);
    settle();
    fork
      brk();
      begin
        @(negedge clk);
        repeat (12) push(FT_INSTR_ADDR, 0);
      end
    join
    settle();
    chk("saw_full", 16'(saw_full), 16'h0001);
    rd_frame(sb.size() - 1);
    // Run past capacity and read across the overflow boundary.
    while (sb.size() < 1005) push(etfc_ftype_t'($urandom_range(3)), ($urandom_range(7) == 0));
    settle();
    chk("trace_overflow_flag", 16'(trace_overflow_flag), 16'h0001);
    rd_frame(0);
    rd_frame(994);
    rd_frame(995);
    rd_frame(999);
    repeat (3) rd_frame($urandom_range(999));
    rd_bad(1000);
    brk();
    final_report();
  end
endmodule : testbench
